// >>> host_port_pkg.sv
/*
  Constants shared by the slave host status and command port.
  Assumes a single 200 MHz system clock and synchronous bus strobes.
*/
package host_port_pkg;

  // Host command codes written to the command port.
  localparam logic [7:0] CMD_CLEAR_REQUEST   = 8'h00;
  localparam logic [7:0] CMD_CONFISCATE      = 8'h01;
  localparam logic [7:0] CMD_RELEASE_RUN     = 8'h03;
  localparam logic [7:0] CMD_CLEAR_RESET     = 8'h80;
  localparam logic [7:0] CMD_HOST_REQUEST    = 8'h40;
  localparam logic [7:0] CMD_HOST_INTERRUPT  = 8'h20;

  // Status byte bit positions.
  localparam int STAT_HARD_BIT       = 7;
  localparam int STAT_IN_SERVICE_BIT = 6;
  localparam int STAT_INT_REQ_BIT    = 5;
  localparam int STAT_SOFT_BIT       = 4;

  // Slave-side port addresses, relocated map.
  localparam logic [10:0] HARD_SERVICE_REQUEST_PORT = 11'h460;
  localparam logic [10:0] SOFTWARE_INTERRUPT_PORT   = 11'h4a0;
  localparam logic [10:0] SOFT_SERVICE_REQUEST_PORT = 11'h520;

  // Slave-side port addresses, legacy map.
  localparam logic [10:0] HARD_PORT_LEGACY = 11'h060;
  localparam logic [10:0] INT_PORT_LEGACY  = 11'h0a0;
  localparam logic [10:0] SOFT_PORT_LEGACY = 11'h120;

  // Memory window limits in 64K pages.
  localparam logic [4:0] MEM_PAGE_MIN = 5'h01;
  localparam logic [4:0] MEM_PAGE_MAX = 5'h1f;

  // Reset values.
  localparam logic RESET_HARD       = 1'b1;
  localparam logic RESET_IN_SERVICE = 1'b1;
  localparam logic RESET_HELD       = 1'b1;

endpackage

// >>> slave_port_decode.sv
/*
  Decoder for the slave-side request ports, in either port map.
  Assumes address and write strobe are synchronous to clk_sys_in.
*/
`timescale 1ns/1ps
module slave_port_decode
  import host_port_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [10:0] addr_in,
  input  wire logic        write_in,
  input  wire logic        relocated_in,
  output logic             hard_hit_out,
  output logic             soft_hit_out,
  output logic             int_hit_out
);

  logic [10:0] hard_addr;
  logic [10:0] soft_addr;
  logic [10:0] int_addr;
  logic        next_hard_hit;
  logic        next_soft_hit;
  logic        next_int_hit;

  always_comb begin
    if (relocated_in) begin
      hard_addr = HARD_SERVICE_REQUEST_PORT;
      soft_addr = SOFT_SERVICE_REQUEST_PORT;
      int_addr  = SOFTWARE_INTERRUPT_PORT;
    end else begin
      hard_addr = HARD_PORT_LEGACY;
      soft_addr = SOFT_PORT_LEGACY;
      int_addr  = INT_PORT_LEGACY;
    end
    next_hard_hit = write_in && (addr_in == hard_addr);
    next_soft_hit = write_in && (addr_in == soft_addr);
    next_int_hit  = write_in && (addr_in == int_addr);
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      hard_hit_out <= 1'b0;
      soft_hit_out <= 1'b0;
      int_hit_out  <= 1'b0;
    end else begin
      hard_hit_out <= next_hard_hit;
      soft_hit_out <= next_soft_hit;
      int_hit_out  <= next_int_hit;
    end
  end

endmodule // slave_port_decode

// >>> slave_host_status_command_port.sv
/*
  Host status and command port of a slave processor board. It holds the
  slave-side request latches, the service and reset latches that suspend
  or hold the slave, the request and interrupt lines towards the slave,
  the registered status read path and the memory window decode.
  Assumes all host and slave strobes are single-cycle pulses that are
  synchronous to clk_sys_in, that the switch and jumper inputs are static
  while the bus is active, and that the slave's bus request handshake and
  the memory path itself live outside this block.
*/
`timescale 1ns/1ps
module slave_host_status_command_port
  import host_port_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  host_io_addr_in,
  input  wire logic        host_io_read_in,
  input  wire logic        host_io_write_in,
  input  wire logic [7:0]  host_data_in,
  input  wire logic [7:0]  io_port_switch_in,
  input  wire logic [20:0] host_mem_addr_in,
  input  wire logic        host_mem_cycle_in,
  input  wire logic [4:0]  mem_page_switch_in,
  input  wire logic [10:0] slave_io_addr_in,
  input  wire logic        slave_io_write_in,
  input  wire logic        port_map_select_jumper_in,
  input  wire logic        slave_int_ack_in,
  output logic [7:0]       host_data_out,
  output logic             host_data_oe_n_out,
  output logic             host_mem_select_out,
  output logic             slave_hold_out,
  output logic             slave_reset_out,
  output logic             host_request_out,
  output logic             host_interrupt_out
);

  typedef enum logic [1:0] {
    SVC_RUN  = 2'b01,
    SVC_HELD = 2'b10
  } service_state_t;

  service_state_t service_state;
  service_state_t next_service_state;
  logic           in_service;
  logic           next_slave_hold;
  logic           next_slave_reset;
  logic           next_host_request;
  logic           next_host_interrupt;

  // Request flags seen by the host.
  logic           hard_req;
  logic           soft_req;
  logic           int_req;
  logic           next_hard_req;
  logic           next_soft_req;
  logic           next_int_req;

  // Registered host bus outputs.
  logic [7:0]     next_host_data;
  logic           next_host_data_oe_n;
  logic           next_host_mem_select;

  // Decoded host accesses and slave port hits.
  logic           port_hit;
  logic           cmd_write;
  logic           status_read;
  logic           page_valid;
  logic           page_match;
  logic           cmd_clear;
  logic           cmd_confiscate;
  logic           cmd_release;
  logic           cmd_reset_clear;
  logic           cmd_host_request;
  logic           cmd_host_interrupt;
  logic           hard_hit;
  logic           soft_hit;
  logic           int_hit;

  slave_port_decode u_decode (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .addr_in      (slave_io_addr_in),
    .write_in     (slave_io_write_in),
    .relocated_in (port_map_select_jumper_in),
    .hard_hit_out (hard_hit),
    .soft_hit_out (soft_hit),
    .int_hit_out  (int_hit)
  );

  // Host port address match and memory window range.
  always_comb begin
    port_hit    = (host_io_addr_in == io_port_switch_in);
    cmd_write   = port_hit && host_io_write_in;
    status_read = port_hit && host_io_read_in;
    page_valid  = (mem_page_switch_in >= MEM_PAGE_MIN) &&
                  (mem_page_switch_in <= MEM_PAGE_MAX);
    page_match  = (host_mem_addr_in[20:16] == mem_page_switch_in);
  end

  // Command decode; an unknown code selects nothing.
  always_comb begin
    cmd_clear          = 1'b0;
    cmd_confiscate     = 1'b0;
    cmd_release        = 1'b0;
    cmd_reset_clear    = 1'b0;
    cmd_host_request   = 1'b0;
    cmd_host_interrupt = 1'b0;
    if (cmd_write) begin
      unique case (host_data_in)
        CMD_CLEAR_REQUEST: begin
          cmd_clear = 1'b1;
        end
        CMD_CONFISCATE: begin
          cmd_confiscate = 1'b1;
        end
        CMD_RELEASE_RUN: begin
          cmd_release = 1'b1;
        end
        CMD_CLEAR_RESET: begin
          cmd_reset_clear = 1'b1;
        end
        CMD_HOST_REQUEST: begin
          cmd_host_request = 1'b1;
        end
        CMD_HOST_INTERRUPT: begin
          cmd_host_interrupt = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // Request flags; a slave set in the same cycle wins over a host clear.
  always_comb begin
    next_hard_req = hard_req;
    next_soft_req = soft_req;
    next_int_req  = int_req;

    if (cmd_clear) begin
      next_hard_req = 1'b0;
      next_soft_req = 1'b0;
      next_int_req  = 1'b0;
    end

    if (hard_hit) begin
      next_hard_req = 1'b1;
    end
    if (soft_hit) begin
      next_soft_req = 1'b1;
    end
    if (int_hit) begin
      next_int_req = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      hard_req <= RESET_HARD;
      soft_req <= 1'b0;
      int_req  <= 1'b0;
    end else begin
      hard_req <= next_hard_req;
      soft_req <= next_soft_req;
      int_req  <= next_int_req;
    end
  end

  // Service state; the hold output follows it in the same cycle.
  always_comb begin
    next_service_state = service_state;
    unique case (service_state)
      SVC_RUN: begin
        if (cmd_confiscate) begin
          next_service_state = SVC_HELD;
        end
      end
      SVC_HELD: begin
        if (cmd_release) begin
          next_service_state = SVC_RUN;
        end
      end
      default: begin
        next_service_state = SVC_HELD;
      end
    endcase

    in_service      = (service_state == SVC_HELD);
    next_slave_hold = (next_service_state == SVC_HELD);
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      service_state  <= RESET_IN_SERVICE ? SVC_HELD : SVC_RUN;
      slave_hold_out <= RESET_IN_SERVICE;
    end else begin
      service_state  <= next_service_state;
      slave_hold_out <= next_slave_hold;
    end
  end

  // Slave reset latch; only the clear command lets the slave run.
  always_comb begin
    next_slave_reset = slave_reset_out;
    if (cmd_reset_clear) begin
      next_slave_reset = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      slave_reset_out <= RESET_HELD;
    end else begin
      slave_reset_out <= next_slave_reset;
    end
  end

  // Request and interrupt to the slave; an acknowledge drops both.
  always_comb begin
    next_host_request   = host_request_out;
    next_host_interrupt = host_interrupt_out;

    if (cmd_host_request) begin
      next_host_request = 1'b1;
    end
    if (cmd_host_interrupt) begin
      next_host_interrupt = 1'b1;
    end

    if (slave_int_ack_in) begin
      next_host_request   = 1'b0;
      next_host_interrupt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      host_request_out   <= 1'b0;
      host_interrupt_out <= 1'b0;
    end else begin
      host_request_out   <= next_host_request;
      host_interrupt_out <= next_host_interrupt;
    end
  end

  // Status read path; reading changes no state and idles at zero.
  always_comb begin
    next_host_data      = 8'h00;
    next_host_data_oe_n = 1'b1;

    if (status_read) begin
      next_host_data[STAT_HARD_BIT]       = hard_req;
      next_host_data[STAT_IN_SERVICE_BIT] = in_service;
      next_host_data[STAT_INT_REQ_BIT]    = int_req;
      next_host_data[STAT_SOFT_BIT]       = soft_req;
      next_host_data_oe_n = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      host_data_out      <= 8'h00;
      host_data_oe_n_out <= 1'b1;
    end else begin
      host_data_out      <= next_host_data;
      host_data_oe_n_out <= next_host_data_oe_n;
    end
  end

  // Memory window; page zero lies below the legal range and disables it.
  always_comb begin
    next_host_mem_select = in_service && host_mem_cycle_in && page_valid &&
                           page_match;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      host_mem_select_out <= 1'b0;
    end else begin
      host_mem_select_out <= next_host_mem_select;
    end
  end

endmodule // slave_host_status_command_port

// >>> host_master_model.sv
/* Host bus master model that polls and commands the slave port.
   Assumes the testbench calls its tasks and shares clk_sys_in. */
`timescale 1ns/1ps
module host_master_model #(
  parameter logic [7:0] PORT = 8'h5a
) (
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] data_in,
  output logic [7:0]      addr_out,
  output logic            rd_out,
  output logic            wr_out,
  output logic [7:0]      data_out
);
  initial begin
    addr_out = 8'h00;
    rd_out = 1'b0;
    wr_out = 1'b0;
    data_out = 8'hff;
  end
  // Commands are plain byte codes on the command port.
  task cmd(input logic [7:0] a, input logic [7:0] c);
    @(posedge clk_sys_in);
    addr_out <= a;
    wr_out <= 1'b1;
    data_out <= c;
    @(posedge clk_sys_in);
    wr_out <= 1'b0;
    data_out <= ~c;
    #1;
  endtask
  task st(output logic [7:0] s);
    @(posedge clk_sys_in);
    addr_out <= PORT;
    rd_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_out <= 1'b0;
    #1 s = data_in;
  endtask
endmodule // host_master_model

// >>> host_port_sva.sv
/* Checker for the slave host status and command port.
   Assumes it is bound to the top module by port name. */
`timescale 1ns/1ps
module host_port_sva (
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic [7:0]  host_io_addr_in,
  input wire logic        host_io_read_in,
  input wire logic        host_io_write_in,
  input wire logic [7:0]  host_data_in,
  input wire logic [7:0]  io_port_switch_in,
  input wire logic [20:0] host_mem_addr_in,
  input wire logic        host_mem_cycle_in,
  input wire logic [4:0]  mem_page_switch_in,
  input wire logic        slave_int_ack_in,
  input wire logic [7:0]  host_data_out,
  input wire logic        host_data_oe_n_out,
  input wire logic        host_mem_select_out,
  input wire logic        slave_hold_out,
  input wire logic        slave_reset_out,
  input wire logic        host_request_out,
  input wire logic        host_interrupt_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic hit;
  logic wm;
  assign hit = host_io_addr_in == io_port_switch_in;
  assign wm = host_io_write_in && hit;
  property p_rd;
    host_io_read_in && hit |=> !host_data_oe_n_out
      && host_data_out[3:0] == 4'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("status read");
  property p_oe;
    !(host_io_read_in && hit) |=> host_data_oe_n_out;
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven");
  property p_cf; wm && host_data_in == 8'h01 |=> slave_hold_out; endproperty
  a_cf: assert property (p_cf) else $error("confiscate");
  property p_rs; wm && host_data_in == 8'h80 |=> !slave_reset_out; endproperty
  a_rs: assert property (p_rs) else $error("reset clear");
  property p_ns;
    host_io_write_in && !hit |=> $stable({slave_reset_out, slave_hold_out});
  endproperty
  a_ns: assert property (p_ns) else $error("foreign port");
  property p_hq;
    wm && host_data_in == 8'h40 && !slave_int_ack_in |=> host_request_out;
  endproperty
  a_hq: assert property (p_hq) else $error("host request");
  property p_hi;
    wm && host_data_in == 8'h20 && !slave_int_ack_in
      |=> host_interrupt_out;
  endproperty
  a_hi: assert property (p_hi) else $error("host interrupt");
  property p_mw;
    host_mem_cycle_in && host_mem_addr_in[20:16] != mem_page_switch_in
      |=> !host_mem_select_out;
  endproperty
  a_mw: assert property (p_mw) else $error("memory window");
  c_rd: cover property (host_io_read_in && hit);
  c_cf: cover property ($rose(slave_hold_out));
  c_ms: cover property (host_mem_select_out);
endmodule // host_port_sva
bind slave_host_status_command_port host_port_sva u_sva (.*);

// >>> slave_host_status_command_port_tb.sv
/* Self-checking testbench for the slave host status and command port.
   Assumes the host master model drives the host I/O strobes. */
`timescale 1ns/1ps
module slave_host_status_command_port_tb;
  logic        clk_sys_in, rst_in, host_io_read_in, host_io_write_in;
  logic [7:0]  host_io_addr_in, host_data_in, host_data_out, s;
  logic [7:0]  port_sw;
  logic [4:0]  page_sw;
  logic [20:0] host_mem_addr_in;
  logic [10:0] slave_io_addr_in, b;
  logic        host_mem_cycle_in, slave_io_write_in, jmp, ack;
  logic        oe_n, msel, hold, sres, hreq, hint;
  wire  [7:0]  pins = {3'h0, hreq, hint, sres, hold, msel};
  int          fails, samples_checked;
  host_master_model HM (.clk_sys_in(clk_sys_in), .data_in(host_data_out),
    .addr_out(host_io_addr_in), .rd_out(host_io_read_in),
    .wr_out(host_io_write_in), .data_out(host_data_in));
  slave_host_status_command_port DUT (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .host_io_addr_in(host_io_addr_in),
    .host_io_read_in(host_io_read_in), .host_io_write_in(host_io_write_in),
    .host_data_in(host_data_in), .io_port_switch_in(port_sw),
    .host_mem_addr_in(host_mem_addr_in), .host_mem_cycle_in(host_mem_cycle_in),
    .mem_page_switch_in(page_sw), .slave_io_addr_in(slave_io_addr_in),
    .slave_io_write_in(slave_io_write_in), .port_map_select_jumper_in(jmp),
    .slave_int_ack_in(ack), .host_data_out(host_data_out),
    .host_data_oe_n_out(oe_n), .host_mem_select_out(msel),
    .slave_hold_out(hold), .slave_reset_out(sres),
    .host_request_out(hreq), .host_interrupt_out(hint));
  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checked %0d, failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task sw(input logic [10:0] a);
    @(posedge clk_sys_in);
    slave_io_addr_in <= a;
    slave_io_write_in <= 1'b1;
    @(posedge clk_sys_in);
    slave_io_write_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
  endtask
  task mcy(input logic [20:0] a);
    @(posedge clk_sys_in);
    host_mem_addr_in <= a;
    host_mem_cycle_in <= 1'b1;
    @(posedge clk_sys_in);
    host_mem_cycle_in <= 1'b0;
    #1;
  endtask
  task t_boot;
    HM.st(s); chk("status", s, 8'hc0);
    chk("oe", {7'h00, oe_n}, 8'h00);
    chk("pins", pins, 8'h06);
    HM.cmd(8'h5a, 8'h80); chk("pins", pins, 8'h02);
    chk("oe", {7'h00, oe_n}, 8'h01);
    chk("idle", host_data_out, 8'h00);
    HM.cmd(8'h5a, 8'h03); chk("pins", pins, 8'h00);
    HM.st(s); HM.st(s); chk("status", s, 8'h80);
    HM.cmd(8'h5a, 8'h00); HM.st(s); chk("status", s, 8'h00);
    $display("boot test done");
  endtask
  task t_flags;
    for (int j = 0; j < 2; j++) begin
      jmp <= j[0];
      b = j[0] ? 11'h400 : 11'h000;
      sw((b ^ 11'h400) | 11'h060); HM.st(s); chk("map", s, 8'h00);
      sw(b | 11'h120); HM.st(s); chk("soft", s, 8'h10);
      chk("pins", pins, 8'h00);
      sw(b | 11'h0a0); HM.st(s); chk("int", s, 8'h30);
      sw(b | 11'h060); HM.st(s); chk("hard", s & 8'hbf, 8'hb0);
      HM.cmd(8'h5a, 8'h03); HM.cmd(8'h5a, 8'h00);
      HM.st(s); chk("clear", s, 8'h00);
      chk("pins", pins, 8'h00);
    end
    $display("flag test done");
  endtask
  task t_host;
    HM.cmd(8'h5a, 8'h01); chk("pins", pins, 8'h02);
    HM.st(s); chk("status", s, 8'h40);
    mcy(21'h020000); chk("pins", pins, 8'h03);
    mcy(21'h030000); chk("pins", pins, 8'h02);
    page_sw <= 5'h00;
    mcy(21'h000000); chk("pins", pins, 8'h02);
    page_sw <= 5'h02;
    HM.cmd(8'h5b, 8'h03); HM.cmd(8'h5a, 8'h02);
    chk("pins", pins, 8'h02);
    port_sw <= 8'hff;
    HM.cmd(8'h5a, 8'h03); chk("pins", pins, 8'h02);
    HM.cmd(8'hff, 8'h03); chk("pins", pins, 8'h00);
    port_sw <= 8'h5a;
    HM.cmd(8'h5a, 8'h03); chk("pins", pins, 8'h00);
    HM.cmd(8'h5a, 8'h40); HM.cmd(8'h5a, 8'h20);
    chk("pins", pins, 8'h18);
    @(posedge clk_sys_in) ack <= 1'b1;
    @(posedge clk_sys_in) ack <= 1'b0;
    #1 chk("pins", pins, 8'h00);
    $display("host test done");
  endtask
  task t_reset;
    sw(11'h520); HM.cmd(8'h5a, 8'h40);
    @(posedge clk_sys_in) rst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    HM.st(s); chk("reset", s, 8'hc0);
    chk("pins", pins, 8'h06);
    $display("reset test done");
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    fails++;
    give_verdict;
  end
  initial begin
    rst_in = 1'b1;
    host_mem_addr_in = 21'h000000;
    host_mem_cycle_in = 1'b0;
    slave_io_addr_in = 11'h000;
    slave_io_write_in = 1'b0;
    jmp = 1'b1;
    ack = 1'b0;
    port_sw = 8'h5a;
    page_sw = 5'h02;
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_boot;
    t_flags;
    t_host;
    t_reset;
    give_verdict;
  end
endmodule // slave_host_status_command_port_tb
